// file: charge_time_edge_control.sv
// Charge-time unit control with ladder reference, AHB-Lite register slave.
// Assumes synchronous edge sources and a comparator two output as input.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
module charge_time_edge_control (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        idle_mode,
  input  wire logic        timer_one_event,
  input  wire logic        output_compare_one,
  input  wire logic [2:0]  input_capture,
  input  wire logic [2:0]  comparator_out,
  input  wire logic [12:0] external_edge_pin,
  output logic             current_source_on,
  output logic             current_source_ground,
  output logic             source_to_second_comparator_b,
  output logic             ladder_to_second_comparator_a,
  output logic             pulse_output,
  output logic             converter_trigger,
  output logic             ladder_power_on,
  output logic             ladder_pin_output_enable,
  output logic             ladder_supply_select,
  output logic [4:0]       ladder_level_select
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic [15:0] ladder_reg;
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic        wr_hit;
  logic        take;
  logic        wr_ctrl_two;
  logic        unit_run;
  logic        gate;
  logic        first_hit;
  logic        second_hit;
  logic        first_set;
  logic        second_set;
  logic        first_next;
  logic        second_next;
  logic        done_reg;
  logic [15:0] first_src;
  logic [15:0] second_src;
  logic [31:0] rd_value;

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= take & hwrite;
      if (take) begin
        wr_addr_reg <= haddr[11:0];
      end
    end
  end

  // Read data is taken at the address edge so it stands in the data
  // phase; a write still in its data phase is forwarded to the read
  assign wr_hit = wr_pend_reg & (wr_addr_reg == haddr[11:0]);

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (haddr[11:0])
      charge_time_pkg::ladder_off: begin
        rd_value[15:0] = wr_hit ?
            (hwdata[15:0] & charge_time_pkg::ladder_mask) : ladder_reg;
      end
      charge_time_pkg::ctrl_one_off: begin
        rd_value[15:0] = wr_hit ?
            (hwdata[15:0] & charge_time_pkg::ctrl_one_mask) : ctrl_one_reg;
      end
      charge_time_pkg::ctrl_two_off: begin
        rd_value[15:0] = ctrl_two_reg;
        if (wr_hit)
          rd_value[15:0] = hwdata[15:0] & charge_time_pkg::ctrl_two_mask;
        rd_value[charge_time_pkg::first_flag_bit]  = first_next;
        rd_value[charge_time_pkg::second_flag_bit] = second_next;
      end
      charge_time_pkg::status_off: begin
        rd_value[4:0] = {done_reg, pulse_output, current_source_on,
                         second_set, first_set};
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      hrdata <= rd_value;
    end
  end

  assign wr_ctrl_two = wr_pend_reg &
                       (wr_addr_reg == charge_time_pkg::ctrl_two_off);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ladder_reg   <= charge_time_pkg::ladder_reset;
      ctrl_one_reg <= charge_time_pkg::ctrl_one_reset;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == charge_time_pkg::ladder_off)
        ladder_reg <= hwdata[15:0] & charge_time_pkg::ladder_mask;
      if (wr_addr_reg == charge_time_pkg::ctrl_one_off)
        ctrl_one_reg <= hwdata[15:0] & charge_time_pkg::ctrl_one_mask;
    end
  end

  // ****************************************************************
  // Edge inputs
  // ****************************************************************
  // Edge one: timer, OC, pins 2,1,3..8, captures 1-3, comparators
  assign first_src = {comparator_out, input_capture,
                      external_edge_pin[7:2], external_edge_pin[0],
                      external_edge_pin[1], output_compare_one,
                      timer_one_event};
  // Edge two: pins 2,1,9..13, captures, an unused code, comparators
  assign second_src = {comparator_out, 1'b0, input_capture,
                       external_edge_pin[12:8], external_edge_pin[0],
                       external_edge_pin[1], output_compare_one,
                       timer_one_event};

  edge_detect u_first (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .sources        (first_src),
    .source_select  (ctrl_two_reg[charge_time_pkg::first_sel_lsb +: 4]),
    .polarity       (ctrl_two_reg[charge_time_pkg::first_pol_bit]),
    .edge_sensitive (ctrl_two_reg[charge_time_pkg::first_sens_bit]),
    .event_hit      (first_hit)
  );

  edge_detect u_second (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .sources        (second_src),
    .source_select  (ctrl_two_reg[charge_time_pkg::second_sel_lsb +: 4]),
    .polarity       (ctrl_two_reg[charge_time_pkg::second_pol_bit]),
    .edge_sensitive (ctrl_two_reg[charge_time_pkg::second_sens_bit]),
    .event_hit      (second_hit)
  );

  // ****************************************************************
  // Edge sequencing and status flags
  // ****************************************************************
  assign unit_run = ctrl_one_reg[charge_time_pkg::unit_enable_bit] &
                    ~(idle_mode &
                      ctrl_one_reg[charge_time_pkg::idle_stop_bit]);
  assign gate = unit_run & ctrl_one_reg[charge_time_pkg::edge_gate_bit];
  assign first_set  = ctrl_two_reg[charge_time_pkg::first_flag_bit];
  assign second_set = ctrl_two_reg[charge_time_pkg::second_flag_bit];

  always_comb begin
    first_next  = first_set;
    second_next = second_set;
    if (wr_ctrl_two) begin
      first_next  = hwdata[charge_time_pkg::first_flag_bit];
      second_next = hwdata[charge_time_pkg::second_flag_bit];
    end
    // Hardware set wins over a software clear in the same cycle
    if (gate & first_hit)
      first_next = 1'b1;
    if (gate & second_hit &
        (~ctrl_one_reg[charge_time_pkg::edge_order_bit] | first_set))
      second_next = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_two_reg <= charge_time_pkg::ctrl_two_reset;
    end else begin
      if (wr_ctrl_two)
        ctrl_two_reg <= hwdata[15:0] & charge_time_pkg::ctrl_two_mask;
      ctrl_two_reg[charge_time_pkg::first_flag_bit]  <= first_next;
      ctrl_two_reg[charge_time_pkg::second_flag_bit] <= second_next;
    end
  end

  // ****************************************************************
  // Current source, pulse and trigger
  // ****************************************************************
  assign current_source_on = unit_run & first_set & ~second_set &
      ~ctrl_one_reg[charge_time_pkg::source_discharge_bit];
  // Grounded by software or automatically once the interval closes
  assign current_source_ground =
      ctrl_one_reg[charge_time_pkg::source_discharge_bit] |
      (first_set & second_set);
  // Pulse spans first to second edge; in delay mode the second edge is
  // the comparator trip, so the pulse ends when the capacitor reaches it
  assign pulse_output = unit_run & first_set & ~second_set;
  assign source_to_second_comparator_b = unit_run &
      ctrl_one_reg[charge_time_pkg::delay_gen_bit];
  assign ladder_to_second_comparator_a = source_to_second_comparator_b &
      ladder_power_on;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg          <= 1'b0;
      converter_trigger <= 1'b0;
    end else begin
      done_reg <= first_next & second_next;
      converter_trigger <= unit_run & first_next & second_next & ~done_reg &
          ctrl_one_reg[charge_time_pkg::trigger_out_en_bit];
    end
  end

  // ****************************************************************
  // Ladder reference
  // ****************************************************************
  assign ladder_power_on = ladder_reg[charge_time_pkg::ladder_power_bit];
  assign ladder_pin_output_enable = ladder_power_on &
      ladder_reg[charge_time_pkg::ladder_pin_oe_bit];
  assign ladder_supply_select =
      ladder_reg[charge_time_pkg::ladder_supply_bit];
  assign ladder_level_select = ladder_reg[4:0];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_gate_block;
    @(posedge hclk) disable iff (!hresetn)
      (!gate && !wr_ctrl_two && !first_set) |=> !first_set;
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("edge passed while gated");

  property p_order;
    @(posedge hclk) disable iff (!hresetn)
      (ctrl_one_reg[10] && !first_set && !second_set && !wr_ctrl_two)
      |=> !second_set;
  endproperty
  a_order: assert property (p_order)
    else $error("second edge taken before first");

  property p_source;
    @(posedge hclk) disable iff (!hresetn)
      current_source_on |-> (first_set && !second_set && unit_run);
  endproperty
  a_source: assert property (p_source)
    else $error("current source on outside interval");

  property p_ground;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_one_reg[9] |-> (current_source_ground && !current_source_on);
  endproperty
  a_ground: assert property (p_ground)
    else $error("discharge did not ground source");

  // Armed: unit running, trigger enabled and the interval still open
  sequence s_armed;
    unit_run && ctrl_one_reg[8] && !(first_set && second_set);
  endsequence
  sequence s_close;
    s_armed ##1 (first_set && second_set);
  endsequence
  property p_trig;
    @(posedge hclk) disable iff (!hresetn)
      s_close |-> converter_trigger;
  endproperty
  a_trig: assert property (p_trig)
    else $error("missing trigger at interval end");

  property p_trig_off;
    @(posedge hclk) disable iff (!hresetn)
      !$past(ctrl_one_reg[8]) |-> !converter_trigger;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("trigger while disabled");

  property p_enable;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl_one_reg[15] |-> (!pulse_output && !current_source_on);
  endproperty
  a_enable: assert property (p_enable)
    else $error("unit active while disabled");

  property p_level;
    @(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_addr_reg == 12'h000)
      |=> ladder_level_select == $past(hwdata[4:0]);
  endproperty
  a_level: assert property (p_level)
    else $error("ladder level not written");

  property p_first_set;
    @(posedge hclk) disable iff (!hresetn)
      (gate && first_hit) |=> first_set;
  endproperty
  a_first_set: assert property (p_first_set)
    else $error("first edge did not set its flag");

  property p_second_set;
    @(posedge hclk) disable iff (!hresetn)
      (gate && second_hit && (!ctrl_one_reg[10] || first_set)) |=> second_set;
  endproperty
  a_second_set: assert property (p_second_set)
    else $error("second edge did not set its flag");

  property p_auto_ground;
    @(posedge hclk) disable iff (!hresetn)
      (first_set && second_set)
      |-> (current_source_ground && !current_source_on && !pulse_output);
  endproperty
  a_auto_ground: assert property (p_auto_ground)
    else $error("source not grounded after interval");

  property p_idle;
    @(posedge hclk) disable iff (!hresetn)
      (idle_mode && ctrl_one_reg[13])
      |-> (!pulse_output && !current_source_on);
  endproperty
  a_idle: assert property (p_idle)
    else $error("unit active in idle with idle stop");

  property p_trig_once;
    @(posedge hclk) disable iff (!hresetn)
      converter_trigger |=> !converter_trigger;
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("trigger longer than one cycle");

endmodule : charge_time_edge_control

// file: charge_time_pkg.sv
// Package for the charge-time edge control block: offsets, fields, resets.
// Assumes an AHB-Lite bus with 32-bit data and word-aligned registers.
package charge_time_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ladder_off  = 12'h000;
  localparam logic [11:0] ctrl_one_off = 12'h004;
  localparam logic [11:0] ctrl_two_off = 12'h008;
  localparam logic [11:0] status_off   = 12'h00c;

  // ****************************************************************
  // Control register one fields
  // ****************************************************************
  localparam int unit_enable_bit       = 15;
  localparam int idle_stop_bit         = 13;
  localparam int delay_gen_bit         = 12;
  localparam int edge_gate_bit         = 11;
  localparam int edge_order_bit        = 10;
  localparam int source_discharge_bit  = 9;
  localparam int trigger_out_en_bit    = 8;
  localparam logic [15:0] ctrl_one_mask  = 16'hbf00;
  localparam logic [15:0] ctrl_one_reset = 16'h0000;

  // ****************************************************************
  // Ladder reference register fields
  // ****************************************************************
  localparam int ladder_power_bit      = 7;
  localparam int ladder_pin_oe_bit     = 6;
  localparam int ladder_supply_bit     = 5;
  localparam int ladder_level_lsb      = 0;
  localparam int ladder_level_width    = 5;
  localparam logic [15:0] ladder_mask  = 16'h00ff;
  localparam logic [15:0] ladder_reset = 16'h0000;

  // ****************************************************************
  // Control register two fields (edge one high byte, edge two low except its flag at bit 9)
  // ****************************************************************
  localparam int first_sens_bit        = 15;
  localparam int first_pol_bit         = 14;
  localparam int first_sel_lsb         = 10;
  localparam int second_flag_bit       = 9;
  localparam int first_flag_bit        = 8;
  localparam int second_sens_bit       = 7;
  localparam int second_pol_bit        = 6;
  localparam int second_sel_lsb        = 2;
  localparam int sel_width             = 4;
  localparam logic [15:0] ctrl_two_mask  = 16'hfffc;
  localparam logic [15:0] ctrl_two_reset = 16'h0000;

endpackage : charge_time_pkg

// file: edge_detect.sv
// One edge input channel: source selection, polarity and sensitivity.
// Assumes all sources are synchronous to hclk.
module edge_detect (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [15:0] sources,
  input  wire logic [3:0]  source_select,
  input  wire logic        polarity,
  input  wire logic        edge_sensitive,
  output logic             event_hit
);

  logic raw;
  logic raw_reg;
  logic level_hit;
  logic edge_hit;

  assign raw       = sources[source_select];
  assign level_hit = polarity ? raw : ~raw;
  // History holds the line itself, reset to its idle low level, so
  // neither reset nor a polarity change looks like an edge
  assign edge_hit  = polarity ? (raw & ~raw_reg) : (~raw & raw_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_reg <= 1'b0;
    end else begin
      raw_reg <= raw;
    end
  end

  // Edge mode fires on the active transition, level mode while active
  assign event_hit = edge_sensitive ? edge_hit : level_hit;

endmodule : edge_detect

// file: far_side_model.sv
// Far side: comparator two with delay capacitor, converter sampling.
// Assumes the block's routing, ladder and pulse outputs drive it directly.
module far_side_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       source_on,
  input  wire logic       source_ground,
  input  wire logic       source_to_b,
  input  wire logic       ladder_to_a,
  input  wire logic       ladder_on,
  input  wire logic [4:0] level,
  input  wire logic       pulse,
  input  wire logic       trigger,
  output logic            cmp_two,
  output logic [7:0]      samples
);
  // ****
  // Capacitor charge, trip and sampling
  // ****
  logic [7:0] cap_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg <= 8'h00;
    end else if (source_ground) begin
      cap_reg <= 8'h00;
    end else if (source_on && source_to_b) begin
      cap_reg <= cap_reg + 8'h01;
    end
  end
  // Trip once the charge reaches the ladder level
  assign cmp_two = source_to_b && ladder_to_a && ladder_on &&
                   (cap_reg >= {3'h0, level});
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samples <= 8'h00;
    end else if (trigger && !pulse) begin
      samples <= samples + 8'h01;
    end
  end
endmodule : far_side_model

// file: charge_time_edge_control_tb.sv
// Self-checking bench for the charge-time edge control block.
// Assumes a zero-wait AHB-Lite slave and the far-side model beside it.
module charge_time_edge_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and instances
  // ****
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, idle = 1'b0;
  logic [12:0] pins = 13'h0;
  logic        on, gnd, to_b, to_a, pulse, trig, cmp2, pwr, oe, ss;
  logic [4:0]  lvl;
  logic [7:0]  samples;
  logic [31:0] q;
  int          n_fail = 0;
  int          checked = 0;
  always #4 hclk = ~hclk;
  charge_time_edge_control i_charge_time_edge_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .idle_mode(idle), .timer_one_event(1'b0),
    .output_compare_one(1'b0), .input_capture(3'h0),
    .comparator_out({1'b0, cmp2, 1'b0}), .external_edge_pin(pins),
    .current_source_on(on), .current_source_ground(gnd),
    .source_to_second_comparator_b(to_b),
    .ladder_to_second_comparator_a(to_a), .pulse_output(pulse),
    .converter_trigger(trig), .ladder_power_on(pwr),
    .ladder_pin_output_enable(oe), .ladder_supply_select(ss),
    .ladder_level_select(lvl));
  far_side_model i_far_side_model (
    .hclk(hclk), .hresetn(hresetn), .source_on(on), .source_ground(gnd),
    .source_to_b(to_b), .ladder_to_a(to_a), .ladder_on(pwr),
    .level(lvl), .pulse(pulse), .trigger(trig), .cmp_two(cmp2),
    .samples(samples));
  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel   <= 1'b1;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
    @(negedge hclk);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk("register", q, exp);
  endtask : rc
  task automatic see(input string nm, input logic [31:0] v, exp);
    @(negedge hclk);
    chk(nm, v, exp);
  endtask : see
  // Counts pulse and trigger cycles; second pin rises at cycle d
  task automatic run(input int d, input int len, output int w, t);
    w = 0;
    t = 0;
    @(posedge hclk);
    pins[0] <= 1'b1;
    for (int i = 1; i <= len; i++) begin
      @(posedge hclk);
      if (i == d) pins[1] <= 1'b1;
      @(negedge hclk);
      if (pulse === 1'b1) w++;
      if (trig === 1'b1) t++;
    end
  endtask : run
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rc(charge_time_pkg::ladder_off, 32'h0);
    rc(charge_time_pkg::ctrl_one_off, 32'h0);
    rc(charge_time_pkg::ctrl_two_off, 32'h0);
    rc(12'hffc, 32'h0);
    chk("bus_resp", {hreadyout, hresp}, 32'h2);
    wr(charge_time_pkg::ladder_off, 32'hffff_ffff);
    rc(charge_time_pkg::ladder_off, 32'h0000_00ff);
    see("ladder", {pwr, oe, ss, lvl}, 32'hff);
    wr(charge_time_pkg::ladder_off, 32'h0000_0046);
    see("ladder", {pwr, oe, ss, lvl}, 32'h06);
    wr(charge_time_pkg::ladder_off, 32'h0000_0086);
    see("ladder", {pwr, oe, ss, lvl}, 32'h86);
    wr(charge_time_pkg::ctrl_one_off, 32'hffff_ffff);
    rc(charge_time_pkg::ctrl_one_off, 32'h0000_bf00);
    wr(charge_time_pkg::ctrl_one_off, 32'h0);
    wr(charge_time_pkg::ctrl_two_off, 32'hffff_ffff);
    rc(charge_time_pkg::ctrl_two_off, 32'h0000_fffc);
    wr(12'h010, 32'hffff_ffff);
    rc(12'h010, 32'h0);
    wr(charge_time_pkg::ctrl_two_off, 32'h0);
  endtask : t_regs
  task automatic t_measure;
    int w, t;
    logic [7:0] s;
    wr(charge_time_pkg::ctrl_two_off, 32'h0000_ccc8);
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_8d00);
    see("routes", {to_b, to_a}, 32'h0);
    @(posedge hclk);
    pins[1] <= 1'b1;
    rc(charge_time_pkg::status_off, 32'h0);
    @(posedge hclk);
    pins[1] <= 1'b0;
    s = samples;
    run(9, 18, w, t);
    chk("width", w, 32'd9);
    chk("trigger", t, 32'd1);
    see("source", {gnd, on}, 32'h2);
    see("samples", samples, s + 8'h01);
    @(posedge hclk);
    pins <= 13'h0;
    wr(charge_time_pkg::ctrl_one_off, 32'h0);
    wr(charge_time_pkg::ctrl_two_off, 32'h0);
  endtask : t_measure
  task automatic t_delay;
    int w, t;
    wr(charge_time_pkg::ctrl_two_off, 32'h0000_ccf8);
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_9800);
    see("routes", {to_b, to_a}, 32'h3);
    run(99, 30, w, t);
    chk("width", w, 32'd7);
    chk("trigger", t, 32'd0);
    see("ground", gnd, 32'h1);
    see("cmp_two", cmp2, 32'h0);
    @(posedge hclk);
    pins <= 13'h0;
    wr(charge_time_pkg::ctrl_one_off, 32'h0);
    wr(charge_time_pkg::ctrl_two_off, 32'h0);
  endtask : t_delay
  task automatic t_source;
    wr(charge_time_pkg::ctrl_two_off, 32'h0000_cc00);
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_8000);
    @(posedge hclk);
    pins[0] <= 1'b1;
    rc(charge_time_pkg::status_off, 32'h0);
    wr(charge_time_pkg::ctrl_two_off, 32'h0000_0100);
    see("source", {gnd, on}, 32'h1);
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_8200);
    see("source", {gnd, on}, 32'h2);
    @(posedge hclk);
    idle <= 1'b1;
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_a000);
    see("source", on, 32'h0);
    wr(charge_time_pkg::ctrl_one_off, 32'h0000_8000);
    see("source", on, 32'h1);
    @(posedge hclk);
    idle <= 1'b0;
    wr(charge_time_pkg::ctrl_one_off, 32'h0);
    see("source", on, 32'h0);
  endtask : t_source
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_measure;
    t_delay;
    t_source;
    tally_and_finish;
  end
endmodule : charge_time_edge_control_tb
